/* rtl/tpg_decoder.sv */
// Purpose: decode six logic inputs into six gate enables per input scheme
// Assumes: pins are asynchronous and pass the three-stage synchroniser
// Notes:   decode is combinational; outputs are registered for timing
`timescale 1ns/1ns
`default_nettype none

module tpg_decoder
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESET,
	// configuration
	input  wire logic       HW_CONFIG,
	input  wire logic [1:0] MODE_FIELD,
	input  wire logic [1:0] MODE_PIN_LEVEL,
	input  wire logic       FREEWHEEL_SELECT,
	// phase inputs, order {C, B, A}
	input  wire logic [2:0] PHASE_HIGH_INPUT,
	input  wire logic [2:0] PHASE_LOW_INPUT,
	// gate enables, order {C, B, A}
	output var  logic [2:0] PHASE_HIGH_GATE,
	output var  logic [2:0] PHASE_LOW_GATE,
	// active scheme
	output var  logic [1:0] ACTIVE_MODE
);

	// ----------------------------------------------------------------
	// synchronised inputs
	// ----------------------------------------------------------------
	logic [2:0] high_s;     // synced high inputs
	logic [2:0] low_s;      // synced low inputs
	logic       hw_s;       // synced hardware config strap
	logic [1:0] field_s;    // synced mode field
	logic [1:0] pinlvl_s;   // synced mode pin level
	logic       fw_s;       // synced freewheel select

	// one synchroniser per asynchronous bit
	logic [11:0] raw_in;    // twelve asynchronous bits, packed
	logic [11:0] sync_out;  // filtered copies of raw_in
	assign raw_in = {FREEWHEEL_SELECT, MODE_PIN_LEVEL, MODE_FIELD, HW_CONFIG,
			PHASE_LOW_INPUT, PHASE_HIGH_INPUT};

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++)
		begin : g_sync
			tpg_sync u_sync
			(
				.clk       (CLK),
				.reset     (RESET),
				.pin_in    (raw_in[gi]),
				.level_out (sync_out[gi])
			);
		end
	endgenerate

	assign high_s   = sync_out[2:0];
	assign low_s    = sync_out[5:3];
	assign hw_s     = sync_out[6];
	assign field_s  = sync_out[8:7];
	assign pinlvl_s = sync_out[10:9];
	assign fw_s     = sync_out[11];

	// ----------------------------------------------------------------
	// mode selection
	// ----------------------------------------------------------------
	logic [1:0] mode_sel;   // decoded scheme

	// pick the source of the scheme
	always_comb
	begin
		if (hw_s)
		begin
			unique case (pinlvl_s)
				tpg_pkg::PIN_LVL_GROUND:  mode_sel = tpg_pkg::MODE_SIX_INPUT;
				tpg_pkg::PIN_LVL_RES_GND: mode_sel = tpg_pkg::MODE_THREE_INPUT;
				tpg_pkg::PIN_LVL_OPEN:    mode_sel = tpg_pkg::MODE_SINGLE_PWM;
				tpg_pkg::PIN_LVL_RAIL:    mode_sel = tpg_pkg::MODE_INDEPENDENT;
			endcase
		end
		else
		begin
			mode_sel = field_s;
		end
	end

	// ----------------------------------------------------------------
	// single-PWM commutation decode
	// ----------------------------------------------------------------
	logic       pwm;        // pwm waveform
	logic       dir;        // rotation direction
	logic       brake_n;    // active low brake
	logic [2:0] cstate;     // raw commutation state
	logic [2:0] norm_state; // state normalised to direction low
	logic [2:0] src;        // source phase {C,B,A}, one-hot except stop
	logic [2:0] snk;        // sink phase {C,B,A}, one-hot except align and stop
	logic [2:0] one_hi;     // single-PWM high gates
	logic [2:0] one_lo;     // single-PWM low gates

	always_comb
	begin
		// pwm and state bits from phase inputs
		pwm        = high_s[0];
		cstate     = {low_s[0], high_s[1], low_s[1]};
		dir        = high_s[2];
		brake_n    = low_s[2];
		norm_state = cstate;
		if (dir && cstate != tpg_pkg::STATE_STOP && cstate != tpg_pkg::STATE_ALIGN)
		begin
			norm_state = ~cstate;
		end
		unique case (norm_state)
			tpg_pkg::STATE_S1:    begin src = 3'h2; snk = 3'h4; end
			tpg_pkg::STATE_S2:    begin src = 3'h1; snk = 3'h4; end
			tpg_pkg::STATE_S3:    begin src = 3'h1; snk = 3'h2; end
			tpg_pkg::STATE_S4:    begin src = 3'h4; snk = 3'h2; end
			tpg_pkg::STATE_S5:    begin src = 3'h4; snk = 3'h1; end
			tpg_pkg::STATE_S6:    begin src = 3'h2; snk = 3'h1; end
			// align: A sources, B and C sink
			tpg_pkg::STATE_ALIGN: begin src = 3'h1; snk = 3'h6; end
			tpg_pkg::STATE_STOP:  begin src = 3'h0; snk = 3'h0; end
		endcase
		one_hi = src & {3{pwm}};
		// inverted pwm on source low gate
		// freewheel keeps it off
		// freewheel exists only on field-configured parts; pin parts rectify
		one_lo = snk | (src & {3{~pwm & ~(fw_s & ~hw_s)}});
		if (!brake_n)
		begin
			one_hi = 3'h0;
			one_lo = 3'h7;
		end
	end

	// ----------------------------------------------------------------
	// gate decode per scheme
	// ----------------------------------------------------------------
	logic [2:0] hi_nxt;     // next high gates
	logic [2:0] lo_nxt;     // next low gates

	always_comb
	begin
		unique case (mode_sel)
			tpg_pkg::MODE_SIX_INPUT:
			begin
				hi_nxt = high_s & ~low_s;
				lo_nxt = low_s & ~high_s;
			end
			tpg_pkg::MODE_THREE_INPUT:
			begin
				hi_nxt = low_s & high_s;
				lo_nxt = low_s & ~high_s;
			end
			tpg_pkg::MODE_SINGLE_PWM:
			begin
				hi_nxt = one_hi;
				lo_nxt = one_lo;
			end
			tpg_pkg::MODE_INDEPENDENT:
			begin
				hi_nxt = high_s;
				lo_nxt = low_s;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	logic [2:0] hi_r;
	logic [2:0] lo_r;
	logic [1:0] mode_r;

	// register only; reset forces all gates off
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			hi_r   <= tpg_pkg::GATES_RESET[2:0];
			lo_r   <= tpg_pkg::GATES_RESET[5:3];
			mode_r <= tpg_pkg::MODE_SIX_INPUT;
		end
		else
		begin
			hi_r   <= hi_nxt;
			lo_r   <= lo_nxt;
			mode_r <= mode_sel;
		end
	end

	assign PHASE_HIGH_GATE = hi_r;
	assign PHASE_LOW_GATE  = lo_r;
	assign ACTIVE_MODE     = mode_r;

endmodule : tpg_decoder

`default_nettype wire

/* rtl/tpg_pkg.sv */
// Purpose: shared constants for the three-phase gate input decoder
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   mode codes and the mode pin level encoding live here
package tpg_pkg;

	// ----------------------------------------------------------------
	// input scheme codes (2-bit mode field)
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SIX_INPUT   = 2'h0;
	localparam logic [1:0] MODE_THREE_INPUT = 2'h1;
	localparam logic [1:0] MODE_SINGLE_PWM  = 2'h2;
	localparam logic [1:0] MODE_INDEPENDENT = 2'h3;

	// ----------------------------------------------------------------
	// mode pin level codes, as reported by the pin level comparator
	// ----------------------------------------------------------------
	localparam logic [1:0] PIN_LVL_GROUND  = 2'h0;
	localparam logic [1:0] PIN_LVL_RES_GND = 2'h1;
	localparam logic [1:0] PIN_LVL_OPEN    = 2'h2;
	localparam logic [1:0] PIN_LVL_RAIL    = 2'h3;

	// ----------------------------------------------------------------
	// reset values and synchroniser depth
	// ----------------------------------------------------------------
	localparam logic [5:0] GATES_RESET = 6'h00;
	localparam int         SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// commutation state patterns, direction input low
	// ----------------------------------------------------------------
	localparam logic [2:0] STATE_STOP  = 3'h0;
	localparam logic [2:0] STATE_ALIGN = 3'h7;
	localparam logic [2:0] STATE_S1    = 3'h6;
	localparam logic [2:0] STATE_S2    = 3'h4;
	localparam logic [2:0] STATE_S3    = 3'h5;
	localparam logic [2:0] STATE_S4    = 3'h1;
	localparam logic [2:0] STATE_S5    = 3'h3;
	localparam logic [2:0] STATE_S6    = 3'h2;

endpackage : tpg_pkg

/* rtl/tpg_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input asynchronous to CLK
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module tpg_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// pin and filtered level
	input  wire logic pin_in,
	output var  logic level_out
);

	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	logic [2:0] stage_r;    // stage_r[0] read only by stage_r[1]
	logic [2:0] stage_nxt;  // next shift value
	logic       level_r;    // filtered level
	logic       level_nxt;  // next filtered level

	// shift and accept a change once stages two and three agree
	always_comb
	begin
		stage_nxt = {stage_r[1:0], pin_in};
		level_nxt = level_r;
		if (stage_r[1] == stage_r[2])
		begin
			level_nxt = stage_r[2];
		end
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stage_r <= 3'h0;
			level_r <= 1'b0;
		end
		else
		begin
			stage_r <= stage_nxt;
			level_r <= level_nxt;
		end
	end

	assign level_out = level_r;

endmodule : tpg_sync

`default_nettype wire

/* dv/tpg_ctrl_model.sv */
// Purpose: controller model driving the six phase inputs
// Assumes: bench sets the wanted pattern at the falling edge
// Notes:   pattern is {C,B,A} high inputs then {C,B,A} low inputs
`timescale 1ns/1ns
`default_nettype none
module tpg_ctrl_model
(
	// clock
	input  wire logic       clk,
	// request from the bench
	input  wire logic       idle,
	input  wire logic [5:0] pattern,
	// phase inputs toward the decoder
	output var  logic [2:0] high_in = 3'h0,
	output var  logic [2:0] low_in  = 3'h0
);
	// drive after the falling edge, one cycle behind the bench
	always @(negedge clk)
	begin
		// hall bits on low A, high B, low B
		// split loads, both may be high
		{high_in, low_in} <= idle ? 6'h00 : pattern;
	end
endmodule : tpg_ctrl_model
`default_nettype wire

/* dv/tpg_decoder_asserts.sv */
// Purpose: port checks for the gate input decoder
// Assumes: one clock, reset active high
// Notes:   decode checks wait for seven steady cycles
`timescale 1ns/1ns
`default_nettype none
module tpg_decoder_asserts
(
	// clock and reset
	input wire logic       CLK,
	input wire logic       RESET,
	// configuration
	input wire logic       HW_CONFIG,
	input wire logic [1:0] MODE_FIELD,
	input wire logic [1:0] MODE_PIN_LEVEL,
	input wire logic       FREEWHEEL_SELECT,
	// phase inputs and gate outputs
	input wire logic [2:0] PHASE_HIGH_INPUT,
	input wire logic [2:0] PHASE_LOW_INPUT,
	input wire logic [2:0] PHASE_HIGH_GATE,
	input wire logic [2:0] PHASE_LOW_GATE,
	input wire logic [1:0] ACTIVE_MODE
);
	wire logic [5:0] ins   = {PHASE_HIGH_INPUT, PHASE_LOW_INPUT}; // all phase inputs
	wire logic [5:0] gates = {PHASE_HIGH_GATE, PHASE_LOW_GATE};   // all gates
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	AST_RESET:
	assert property (disable iff (1'b0) RESET |=> gates == 6'h00 && ACTIVE_MODE == 2'h0)
		else $error("outputs not cleared");
	AST_FIELD:
	assert property ((!HW_CONFIG && $stable(MODE_FIELD) && $stable(HW_CONFIG))[*7]
		|-> ACTIVE_MODE == MODE_FIELD) else $error("field mode not taken");
	AST_PIN:
	assert property ((HW_CONFIG && $stable(MODE_PIN_LEVEL) && $stable(HW_CONFIG))[*7]
		|-> ACTIVE_MODE == MODE_PIN_LEVEL) else $error("pin mode not taken");
	AST_SIX:
	assert property ((ACTIVE_MODE == 2'h0 && $stable(ins))[*7] |-> PHASE_HIGH_GATE ==
		(PHASE_HIGH_INPUT & ~PHASE_LOW_INPUT) && PHASE_LOW_GATE ==
		(PHASE_LOW_INPUT & ~PHASE_HIGH_INPUT)) else $error("six-input decode");
	AST_HIZ:
	assert property ((ACTIVE_MODE == 2'h1 && !PHASE_LOW_INPUT[0])[*7]
		|-> !PHASE_HIGH_GATE[0] && !PHASE_LOW_GATE[0]) else $error("phase not off");
	AST_BRAKE:
	assert property ((ACTIVE_MODE == 2'h2 && !PHASE_LOW_INPUT[2])[*7]
		|-> gates == 6'h07) else $error("brake not applied");
	AST_INDEP:
	assert property ((ACTIVE_MODE == 2'h3 && $stable(ins))[*7] |-> gates == ins)
		else $error("independent decode");
	AST_FREEWHEEL:
	assert property ((ACTIVE_MODE == 2'h2 && !HW_CONFIG && FREEWHEEL_SELECT &&
		PHASE_LOW_INPUT[2] && !PHASE_HIGH_INPUT[0] && $stable(ins))[*7]
		|-> PHASE_HIGH_GATE == 3'h0 && PHASE_LOW_GATE != 3'h7)
		else $error("source low gate not left off");
	AST_NO_OVERLAP:
	assert property (ACTIVE_MODE != 2'h3 |-> (PHASE_HIGH_GATE & PHASE_LOW_GATE) == 3'h0)
		else $error("both gates of a phase on");
endmodule : tpg_decoder_asserts

bind tpg_decoder tpg_decoder_asserts checker_inst
(
	.CLK(CLK), .RESET(RESET), .HW_CONFIG(HW_CONFIG), .MODE_FIELD(MODE_FIELD),
	.MODE_PIN_LEVEL(MODE_PIN_LEVEL), .FREEWHEEL_SELECT(FREEWHEEL_SELECT),
	.PHASE_HIGH_INPUT(PHASE_HIGH_INPUT), .PHASE_LOW_INPUT(PHASE_LOW_INPUT),
	.PHASE_HIGH_GATE(PHASE_HIGH_GATE), .PHASE_LOW_GATE(PHASE_LOW_GATE),
	.ACTIVE_MODE(ACTIVE_MODE)
);
`default_nettype wire

/* dv/three_phase_gate_input_decoder_test.sv */
// Purpose: self-checking bench for the gate input decoder
// Assumes: 20 MHz clock, inputs change at the falling edge
// Notes:   every scheme is swept through all 64 input patterns
`timescale 1ns/1ns
`default_nettype none
module three_phase_gate_input_decoder_test;
	logic            clk       = 1'b0;  // 50 ns clock
	logic            reset     = 1'b1;  // synchronous reset
	logic            hw_config = 1'b0;  // scheme source
	logic [1:0]      mode_fld  = 2'h0;
	logic [1:0]      mode_pin  = 2'h0;
	logic            freewheel = 1'b0;
	logic            idle      = 1'b1;  // controller inputs low
	logic [5:0]      pattern   = 6'h00;
	logic [5:0]      mask;
	wire logic [2:0] high_in, low_in, high_gate, low_gate;
	wire logic [1:0] active_mode;
	int              bad_count = 0;
	int              compares  = 0;
	int              cycles    = 0;
	int              seed      = 81;

	tpg_decoder dut
	(
		.CLK(clk), .RESET(reset), .HW_CONFIG(hw_config), .MODE_FIELD(mode_fld),
		.MODE_PIN_LEVEL(mode_pin), .FREEWHEEL_SELECT(freewheel),
		.PHASE_HIGH_INPUT(high_in), .PHASE_LOW_INPUT(low_in),
		.PHASE_HIGH_GATE(high_gate), .PHASE_LOW_GATE(low_gate), .ACTIVE_MODE(active_mode)
	);
	tpg_ctrl_model ctrl
	(
		.clk(clk), .idle(idle), .pattern(pattern), .high_in(high_in), .low_in(low_in)
	);

	// clock and hang limit
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			bad_count++;
			close_out();
		end
	end

	// expected gates {high, low} from the scheme tables
	function automatic logic [5:0] model(input int m, input int fw, input logic [2:0] h,
		input logic [2:0] l);
		int         src[8] = '{0, 2, 1, 2, 0, 0, 1, 0}; // source phase per state
		int         snk[8] = '{0, 1, 0, 0, 2, 1, 2, 1}; // sink phase per state
		int         st;
		logic [2:0] hg = 3'h0;
		logic [2:0] lg = 3'h0;
		st = {l[0], h[1], l[1]};
		if (h[2] && st != 0 && st != 7)
			st = 7 - st;
		case (m)
			0: {hg, lg} = {h & ~l, l & ~h};
			1: {hg, lg} = {h & l, ~h & l};
			2:
			begin
				if (!l[2])
					lg = 3'h7;
				else if (st != 0)
				begin
					hg[src[st]] = h[0];
					lg[src[st]] = !h[0] && fw == 0;
					lg[snk[st]] = 1'b1;
					if (st == 7)
						lg[2] = 1'b1;
				end
			end
			default: {hg, lg} = {h, l};
		endcase
		return {hg, lg};
	endfunction : model

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_mode

	// one scheme, all 64 patterns under a random mask
	task automatic run_pass(input int hw, input int m, input int fw);
		logic [5:0] exp_gates; // expected {high, low} gates
		mask = 6'($random(seed));
		idle <= 1'b1;
		repeat (8) @(negedge clk);
		hw_config <= hw[0];
		mode_fld <= hw ? ~m[1:0] : m[1:0];
		mode_pin <= hw ? m[1:0] : ~m[1:0];
		freewheel <= fw[0];
		repeat (8) @(negedge clk);
		idle <= 1'b0;
		for (int i = 0; i < 64; i++)
		begin
			pattern <= i[5:0] ^ mask;
			repeat (8) @(negedge clk);
			chk_mode(active_mode, m[1:0]);
			// freewheel only counts on field-configured parts
			exp_gates = model(m, hw ? 0 : fw, pattern[5:3], pattern[2:0]);
			chk({2'h0, high_gate, low_gate}, {2'h0, exp_gates});
		end
	endtask : run_pass

	task automatic close_out();
		$display("mismatches %0d, compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	// reset, then every scheme from both sources
	initial
	begin
		repeat (20) @(negedge clk);
		chk({2'h0, high_gate, low_gate}, 8'h00);
		chk_mode(active_mode, 2'h0);
		reset <= 1'b0;
		for (int hw = 0; hw < 2; hw++)
			for (int m = 0; m < 4; m++)
				for (int fw = 0; fw < 1 + int'(m == 2); fw++)
					run_pass(hw, m, fw);
		close_out();
	end
endmodule : three_phase_gate_input_decoder_test
`default_nettype wire
